// File: hw/pcd_regs.svh
/*
 second-stage synthesizer control constants: settings ranges, calibration timing, channel layout.
 assumes inclusion by bare name from design files under hw/.
*/
// Functional notes
// - selectable doubler makes phase detector reference twice the oscillator input
// - reference prescaler divides 1 through 31, input up to 275 MHz
// - normal feedback is 8-bit main divider times rf output divider
// - calibration divider in loop only during calibration, then reverts automatically
// - calibration total is four times main counter plus swallow counter
// - main counter 3..63, swallow 0..3, total at least 16
// - rf output divider supports only 3, 4 and 5
// - calibration starts only on rising calibrate bit; software clears it
// - calibrate request takes effect on register transfer strobe
// - in-progress status reads 1 during calibration, clears when done
// - every calibration completion triggers an automatic output sync
// - after reset rf-fed channels held in sync until first calibration completes
// - calibration completes within 400,000 phase detector cycles
// - fourteen channels, each 8-bit divider, source first, second stage or sysref
// - coarse delay only through channel divider; sysref needs divider retiming
// - sync resets channel dividers; bypassed or unretimed sysref channels unsynced
`ifndef PCD_REGS_SVH
`define PCD_REGS_SVH
// ==========================================================
// register locations kept for reference; bits arrive as ports
`define PCD_OFS_CAL_CTRL    16'h0203
`define PCD_OFS_XFER        16'h000F
`define PCD_OFS_CAL_STAT    16'h0509
`define PCD_OFS_SYNC        16'h032A
`define PCD_BIT_CAL         0
`define PCD_BIT_XFER        0
`define PCD_BIT_BUSY        0
`define PCD_BIT_SYNC        0
// ==========================================================
// divider ranges
`define PCD_PRE_MIN         5'h01
`define PCD_PRE_MAX         5'h1F
`define PCD_PRE_FIN_MHZ     275
`define PCD_CAL_MOD         4
`define PCD_CALB_MIN        6'h03
`define PCD_CALB_MAX        6'h3F
`define PCD_CALA_MAX        2'h3
`define PCD_CAL_TOT_MIN     9'h010
`define PCD_RF_DIV3         3'h3
`define PCD_RF_DIV5         3'h5
// ==========================================================
// calibration timing in phase detector cycles; channel count; sync length in clock cycles
`define PCD_CAL_PFD_CYCLES  400000
`define PCD_NCH             14
`define PCD_SYNC_CYCLES     4'h8
// ==========================================================
// channel source codes; reset divider values
`define PCD_SRC_STAGE1      2'h0
`define PCD_SRC_STAGE2      2'h1
`define PCD_SRC_SYSREF      2'h2
`define PCD_RST_PRE         5'h01
`define PCD_RST_MAIN        8'h0A
`define PCD_RST_RF          3'h3
`endif

// File: hw/pcd_pkg.sv
/*
 types for the second-stage synthesizer control block.
 assumes pcd_regs.svh is compiled alongside.
*/
package pcd_pkg;
   typedef enum logic [1:0] {
      PCD_IDLE = 2'b00,
      PCD_CAL  = 2'b01,
      PCD_SYNC = 2'b10
   } pcd_state_t;
   typedef enum logic [1:0] {
      PCD_SEL_STAGE1 = 2'b00,
      PCD_SEL_STAGE2 = 2'b01,
      PCD_SEL_SYSREF = 2'b10
   } pcd_src_t;
endpackage

// File: hw/pcd_div_check.sv
/*
 combinational legality check of the feedback divider settings.
 assumes settings come from registers on the same clock.
*/
`timescale 1ns/1ns
`include "pcd_regs.svh"
module pcd_div_check (
   input  wire logic [4:0] pre_div,
   input  wire logic [7:0] main_div,
   input  wire logic [2:0] rf_div,
   input  wire logic [5:0] cal_b,
   input  wire logic [1:0] cal_a,
   output logic       [10:0] normal_total,
   output logic       [8:0]  cal_total,
   output logic              cfg_ok
);
   // ==========================================================
   // totals
   always_comb begin
      normal_total = 11'(main_div * rf_div);
      cal_total    = 9'(`PCD_CAL_MOD * cal_b) + 9'(cal_a);
      cfg_ok = (pre_div >= `PCD_PRE_MIN) && (pre_div <= `PCD_PRE_MAX)
            && (rf_div >= `PCD_RF_DIV3) && (rf_div <= `PCD_RF_DIV5)
            && (cal_b >= `PCD_CALB_MIN) && (cal_a <= `PCD_CALA_MAX)
            && (cal_total >= `PCD_CAL_TOT_MIN);
   end
endmodule // pcd_div_check

// File: hw/pcd_chan.sv
/*
 one distribution channel: 8-bit divider with synchronous reset and coarse delay gating.
 assumes the channel clock tick arrives as a same-clock enable.
*/
`timescale 1ns/1ns
module pcd_chan (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       tick,
   input  wire logic [1:0] src,
   input  wire logic       use_div,
   input  wire logic       sysref_retime,
   input  wire logic [7:0] div,
   input  wire logic [5:0] coarse,
   input  wire logic       sync,
   input  wire logic       hold,
   output logic            out
);
   typedef struct packed {
      logic [7:0] cnt;
      logic [5:0] dly;
      logic       q;
   } pcd_ch_t;
   pcd_ch_t r, next_r;
   logic    via_div;
   // ==========================================================
   // divider path; sysref only uses the divider when retimed
   always_comb begin
      next_r  = r;
      via_div = use_div && ((src != pcd_pkg::PCD_SEL_SYSREF) || sysref_retime);
      if (sync && via_div) begin
         next_r.cnt = 8'h00;
         next_r.dly = coarse;
         next_r.q   = 1'b0;
      end else if (tick) begin
         if (via_div && r.dly != 6'h00) begin
            next_r.dly = r.dly - 6'h01;
         end else if (r.cnt >= div) begin
            next_r.cnt = 8'h00;
            next_r.q   = ~r.q;
         end else begin
            next_r.cnt = r.cnt + 8'h01;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   // held divider-path and stage-2 channels show no clock; other bypassed channels pass the tick straight through
   always_comb begin
      if (hold && (via_div || src == pcd_pkg::PCD_SEL_STAGE2)) begin
         out = 1'b0;
      end else if (via_div) begin
         out = r.q;
      end else begin
         out = tick;
      end
   end
endmodule // pcd_chan

// File: hw/pcd_ctrl.sv
/*
 second-stage synthesizer calibration control and channel sync sequencing.
 assumes all control bits arrive from same-clock register logic; the phase detector
 tick is a same-clock pulse, and the calibration-done pin is asynchronous.
*/
`timescale 1ns/1ns
`include "pcd_regs.svh"
module pcd_ctrl #(
   parameter int unsigned CAL_TIMEOUT = `PCD_CAL_PFD_CYCLES
) (
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    doubler_en,
   input  wire logic [4:0]              pre_div,
   input  wire logic [7:0]              main_div,
   input  wire logic [2:0]              rf_div,
   input  wire logic [5:0]              cal_b,
   input  wire logic [1:0]              cal_a,
   input  wire logic                    cal_bit,
   input  wire logic                    xfer_strobe,
   input  wire logic                    sync_bit,
   input  wire logic                    pfd_tick,
   input  wire logic                    cal_done_pin,
   input  wire logic                    ch_tick,
   input  wire logic [27:0]             ch_src,
   input  wire logic [13:0]             ch_use_div,
   input  wire logic [13:0]             ch_retime,
   input  wire logic [111:0]            ch_div,
   input  wire logic [83:0]             ch_coarse,
   output logic                         cal_busy,
   output logic                         cal_fb_sel,
   output logic                         ref_doubled,
   output logic                         cfg_error,
   output logic                         cal_timeout,
   output logic [13:0]                  clock_output_channels
);
   localparam int unsigned CW = 19;
   typedef struct packed {
      pcd_pkg::pcd_state_t st;
      logic                cal_shadow;
      logic                cal_prev;
      logic                sync_prev;
      logic                first_done;
      logic [CW-1:0]       pfd_cnt;
      logic [3:0]          sync_cnt;
      logic                done_s1;
      logic                done_s2;
      logic                busy;
      logic                fb_sel;
      logic                dbl;
      logic                err;
      logic                tmo;
      logic [13:0]         outs;
   } pcd_ctrl_t;
   pcd_ctrl_t   r, next_r;
   logic [10:0] normal_total;
   logic [8:0]  cal_total;
   logic        cfg_ok;
   logic [13:0] ch_out;
   logic        cal_start;
   logic        sync_pulse;
   logic        hold;
   // ==========================================================
   // divider legality
   pcd_div_check u_chk (
      .pre_div      (pre_div),
      .main_div     (main_div),
      .rf_div       (rf_div),
      .cal_b        (cal_b),
      .cal_a        (cal_a),
      .normal_total (normal_total),
      .cal_total    (cal_total),
      .cfg_ok       (cfg_ok)
   );
   // ==========================================================
   // channels
   genvar g;
   generate
      for (g = 0; g < `PCD_NCH; g++) begin : g_ch
         pcd_chan u_ch (
            .clk           (clk),
            .srst          (srst),
            .tick          (ch_tick),
            .src           (ch_src[2*g +: 2]),
            .use_div       (ch_use_div[g]),
            .sysref_retime (ch_retime[g]),
            .div           (ch_div[8*g +: 8]),
            .coarse        (ch_coarse[6*g +: 6]),
            .sync          (sync_pulse),
            .hold          (hold),
            .out           (ch_out[g])
         );
      end
   endgenerate
   // ==========================================================
   // sequencing
   always_comb begin
      next_r = r;
      // calibrate bit only counts once the transfer strobe copies it in
      if (xfer_strobe) begin
         next_r.cal_shadow = cal_bit;
      end
      next_r.cal_prev  = r.cal_shadow;
      next_r.sync_prev = sync_bit;
      cal_start  = r.cal_shadow && !r.cal_prev;
      // manual sync fires on the falling edge of the sync bit
      sync_pulse = (r.st == pcd_pkg::PCD_SYNC) || (r.sync_prev && !sync_bit);
      hold       = !r.first_done || (r.st == pcd_pkg::PCD_SYNC);
      next_r.done_s1 = cal_done_pin;
      next_r.done_s2 = r.done_s1;
      next_r.dbl     = doubler_en;
      unique case (r.st)
         pcd_pkg::PCD_IDLE: begin
            if (cal_start) begin
               next_r.st      = pcd_pkg::PCD_CAL;
               next_r.pfd_cnt = '0;
               next_r.err     = !cfg_ok || (11'(cal_total) != normal_total);
               next_r.tmo     = 1'b0;
            end
         end
         pcd_pkg::PCD_CAL: begin
            if (pfd_tick) begin
               next_r.pfd_cnt = r.pfd_cnt + CW'(1);
            end
            // analog done or the maximum calibration length bounds the run
            if (r.done_s2 || (r.pfd_cnt >= CW'(CAL_TIMEOUT - 1))) begin
               next_r.tmo      = !r.done_s2;
               next_r.st       = pcd_pkg::PCD_SYNC;
               next_r.sync_cnt = `PCD_SYNC_CYCLES;
            end
         end
         pcd_pkg::PCD_SYNC: begin
            next_r.sync_cnt = r.sync_cnt - 4'h1;
            if (r.sync_cnt == 4'h1) begin
               next_r.st         = pcd_pkg::PCD_IDLE;
               next_r.first_done = 1'b1;
            end
         end
         default: begin
            next_r.st = pcd_pkg::PCD_IDLE;
         end
      endcase
      next_r.busy   = (next_r.st == pcd_pkg::PCD_CAL);
      next_r.fb_sel = (next_r.st == pcd_pkg::PCD_CAL);
      next_r.outs   = ch_out;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign cal_busy              = r.busy;
   assign cal_fb_sel            = r.fb_sel;
   assign ref_doubled           = r.dbl;
   assign cfg_error             = r.err;
   assign cal_timeout           = r.tmo;
   assign clock_output_channels = r.outs;
endmodule // pcd_ctrl

// File: test/pcd_ctrl_sva.sv
/*
 port assertions for pcd_ctrl.
 assumes one clock and the synchronous active-high reset srst.
*/
`timescale 1ns/1ns
module pcd_ctrl_sva #(
   parameter int unsigned CAL_TIMEOUT = 20
) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        doubler_en,
   input wire logic [4:0]  pre_div,
   input wire logic [7:0]  main_div,
   input wire logic [2:0]  rf_div,
   input wire logic [5:0]  cal_b,
   input wire logic [1:0]  cal_a,
   input wire logic        cal_bit,
   input wire logic        xfer_strobe,
   input wire logic        pfd_tick,
   input wire logic        cal_done_pin,
   input wire logic [27:0] ch_src,
   input wire logic [13:0] ch_use_div,
   input wire logic        cal_busy,
   input wire logic        cal_fb_sel,
   input wire logic        ref_doubled,
   input wire logic        cfg_error,
   input wire logic [13:0] clock_output_channels
);
   logic        sh, seen, bad;
   logic [3:0]  q;
   logic [31:0] n;
   logic [13:0] ms;
   logic [8:0]  ct;
   // ==========================================
   // helpers: q saturates once sync is surely over
   assign ct  = 9'({cal_b, 2'b00}) + 9'(cal_a);
   assign bad = pre_div == 5'h0 || ct < 9'h010 || 11'(ct) != 11'(main_div) * 11'(rf_div) ||
                rf_div < 3'h3 || rf_div > 3'h5;
   always_comb for (int i = 0; i < 14; i++) ms[i] = ch_use_div[i] && ch_src[2*i+:2] == 2'h1;
   always_ff @(posedge clk) begin
      sh   <= srst ? 1'b0 : (xfer_strobe ? cal_bit : sh);
      q    <= srst ? 4'hF : (cal_busy ? 4'h0 : q + 4'(q != 4'hF));
      n    <= cal_busy ? n + 32'(pfd_tick) : 32'h0;
      seen <= !srst && (seen || q == 4'h1);
   end
   // ==========================================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_cal_start: assert property (xfer_strobe && cal_bit && !sh && q == 4'hF && !bad
      |-> ##1 !cal_busy ##1 cal_busy)
      else $error("calibration start latency wrong");
   a_no_spont: assert property ($rose(cal_busy) |-> $past(xfer_strobe, 2) && $past(cal_bit, 2))
      else $error("calibration began without request");
   a_fb_path: assert property (cal_fb_sel == cal_busy)
      else $error("feedback select differs from calibration");
   a_done_end: assert property (cal_busy && $rose(cal_done_pin) |-> ##[1:3] !cal_busy)
      else $error("busy outlived done");
   a_cal_bound: assert property (cal_busy |-> n <= CAL_TIMEOUT + 1)
      else $error("calibration overran its count");
   a_dbl_copy: assert property (!$past(srst) |-> ref_doubled == $past(doubler_en))
      else $error("doubler state not copied");
   a_cfg_flag: assert property ($rose(cal_busy) && bad |-> ##[0:1] cfg_error)
      else $error("illegal settings not flagged");
   a_sync_low: assert property ($fell(cal_busy) |-> ##2 ((clock_output_channels & ms) == 14'h0) [*5])
      else $error("no sync after calibration");
   a_hold_first: assert property (!seen |-> (clock_output_channels & ms) == 14'h0)
      else $error("channel ran before first calibration");
endmodule // pcd_ctrl_sva
bind pcd_ctrl pcd_ctrl_sva #(.CAL_TIMEOUT(CAL_TIMEOUT)) u_pcd_ctrl_sva (.clk, .srst, .doubler_en, .pre_div,
   .main_div, .rf_div, .cal_b, .cal_a, .cal_bit, .xfer_strobe, .pfd_tick, .cal_done_pin, .ch_src, .ch_use_div,
   .cal_busy, .cal_fb_sel, .ref_doubled, .cfg_error, .clock_output_channels);

// File: test/pcd_vcxo.sv
/*
 oscillator and vco model: phase detector ticks and calibration done.
 assumes the same clock as the block.
*/
`timescale 1ns/1ns
module pcd_vcxo (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic doubled,
   input  wire logic fb_sel,
   input  wire logic slow,
   output logic      pfd_tick,
   output logic      done
);
   logic [1:0] ph;
   logic [7:0] cnt;
   always_ff @(posedge clk) begin
      ph  <= srst ? 2'h0 : ph + 2'h1;   // clock always present, same phase after every reset
      cnt <= fb_sel ? cnt + 8'h01 : 8'h00;
   end
   assign pfd_tick = doubled ? ph[0] : (ph == 2'h3);   // twice the rate
   // slow never settles, so only the count can end it
   assign done = fb_sel && !slow && cnt > 8'h06;
endmodule // pcd_vcxo

// File: test/pcd_ctrl_tb_top.sv
/*
 self-checking bench for pcd_ctrl with the oscillator model.
 assumes 250 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
module pcd_ctrl_tb_top;
   logic         clk = 1'b0, srst = 1'b1, doubler_en = 1'b0, cal_bit = 1'b0, xfer_strobe = 1'b0;
   logic         sync_bit = 1'b0, ch_tick = 1'b0, slow = 1'b0;
   logic [4:0]   pre_div = 5'h01;
   logic [7:0]   main_div = 8'h0A, m, t;
   logic [2:0]   rf_div = 3'h3, r;
   logic [5:0]   cal_b = 6'h07;
   logic [1:0]   cal_a = 2'h2;
   logic [27:0]  ch_src = '0;
   logic [13:0]  ch_use_div = '0, ch_retime = '0, any, clock_output_channels;
   logic [111:0] ch_div = '0;
   logic [83:0]  ch_coarse = '0;
   logic         cal_busy, cal_fb_sel, ref_doubled, cfg_error, cal_timeout, pfd_tick, cal_done_pin;
   int           num_errors = 0, n_compared = 0, i, k;
   always #2 clk = ~clk;
   always @(negedge clk) ch_tick <= ~ch_tick;
   pcd_ctrl #(.CAL_TIMEOUT(20)) u_pcd_ctrl (.clk, .srst, .doubler_en, .pre_div, .main_div, .rf_div, .cal_b,
      .cal_a, .cal_bit, .xfer_strobe, .sync_bit, .pfd_tick, .cal_done_pin, .ch_tick, .ch_src, .ch_use_div,
      .ch_retime, .ch_div, .ch_coarse, .cal_busy, .cal_fb_sel, .ref_doubled, .cfg_error, .cal_timeout,
      .clock_output_channels);
   pcd_vcxo u_pcd_vcxo (.clk, .srst, .doubled(ref_doubled), .fb_sel(cal_fb_sel), .slow, .pfd_tick,
      .done(cal_done_pin));
   // ==========================================
   // helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("errors %0d compares %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic exp_err(input logic [7:0] dm, input logic [2:0] dr, input logic [7:0] dt);
      return dt < 8'h10 || int'(dt) != int'(dm) * int'(dr) || dr < 3'h3 || dr > 3'h5;
   endfunction
   task automatic strobe(input logic b);
      cal_bit = b;
      xfer_strobe = 1'b1;
      @(negedge clk) xfer_strobe = 1'b0;
   endtask
   task automatic watch();
      any = '0;
      repeat (40) begin
         @(negedge clk);
         any |= clock_output_channels;
      end
   endtask
   // bit is cleared first so every call makes a fresh rising edge
   task automatic run_cal(input logic e);
      strobe(1'b0);
      // let an edge pass with the strobe low so it is never driven twice at once
      @(negedge clk);
      strobe(1'b1);
      if (e) chk(cal_busy, 1'b0);
      @(negedge clk);
      if (e) chk(cal_busy, 1'b1);
      if (e) chk(cal_fb_sel, 1'b1);
      for (i = 0; i < 200 && cal_busy !== 1'b0; i++) @(negedge clk);   // bounded wait
      chk(cal_busy, 1'b0);
      if (cal_busy !== 1'b0) close_out();
      chk(cal_fb_sel, 1'b0);
      repeat (16) @(negedge clk);
   endtask
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(27));
      for (i = 0; i < 14; i++) begin
         ch_src[2*i+:2] = 2'($urandom_range(2, 0));
         ch_div[8*i+:8] = 8'($urandom_range(3, 0));
      end
      ch_use_div = 14'($urandom);
      ch_retime = 14'($urandom);
      ch_src[1:0] = 2'h1;
      ch_use_div[0] = 1'b1;
      repeat (8) @(negedge clk);
      srst = 1'b0;
      watch();
      chk(any[0], 1'b0);
      run_cal(1'b1);
      chk(cal_timeout, 1'b0);
      watch();
      chk(any[0], 1'b1);
      strobe(1'b1);
      repeat (3) @(negedge clk);
      chk(cal_busy, 1'b0);
      for (k = 0; k < 8; k++) begin
         r = 3'($urandom_range(6, 3));
         m = 8'($urandom_range(40, 4));
         t = 8'(m * r);
         if (k == 1) t = t + 8'h01;
         if (k == 2) {m, r, t} = {8'h05, 3'h3, 8'h0F};
         doubler_en = k[0] && t > 8'h10;   // doubler only above 16
         {main_div, rf_div, cal_b, cal_a} = {m, r, t};
         run_cal(!exp_err(m, r, t));       // recalibrate after divider change
         chk(cfg_error, exp_err(m, r, t));
         chk(ref_doubled, doubler_en);
      end
      {main_div, rf_div, cal_b, cal_a} = {8'h0A, 3'h3, 8'h1E};
      slow = 1'b1;
      run_cal(1'b1);
      chk(cal_timeout, 1'b1);
      // coarse value only loads on a sync, so a missed sync leaves channel 0 toggling
      ch_coarse[5:0] = 6'h3F;
      sync_bit = 1'b1;
      @(negedge clk) sync_bit = 1'b0;
      repeat (2) @(negedge clk);
      watch();
      chk(any[0], 1'b0);
      close_out();
   end
endmodule // pcd_ctrl_tb_top
